// ---- design/spi_pkg.sv ----
// constants, field layouts and carrier types of the serial controller
// assumes a 32-bit classic wishbone bus, one register per aligned word
package spi_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL_A = 6'h00;
    localparam logic [5:0] IDX_CTRL_B = 6'h01;
    localparam logic [5:0] IDX_INT_EN = 6'h02;
    localparam logic [5:0] IDX_FLAGS  = 6'h03;
    localparam logic [5:0] IDX_DATA   = 6'h04;

    // writable bits and reset values
    localparam logic [7:0] CTRL_A_MASK   = 8'h77;
    localparam logic [7:0] CTRL_B_MASK   = 8'hc7;
    localparam logic [7:0] INT_EN_MASK   = 8'hf1;
    localparam logic [7:0] INT_EN_NORMAL = 8'h01;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // flag positions, normal mode
    localparam int POS_DONE   = 7;
    localparam int POS_WRITE_COLLISION_FLAG  = 6;
    // flag positions, buffered mode
    localparam int POS_RXC    = 7;
    localparam int POS_TXC    = 6;
    localparam int POS_DRE    = 5;
    localparam int POS_SSI    = 4;
    localparam int POS_OVF    = 0;

    // prescaler divide ratios of the peripheral clock
    localparam logic [7:0] DIVIDE_BY_FOUR           = 8'h04;
    localparam logic [7:0] DIVIDE_BY_SIXTEEN        = 8'h10;
    localparam logic [7:0] DIVIDE_BY_SIXTYFOUR      = 8'h40;
    localparam logic [7:0] DIVIDE_BY_ONETWENTYEIGHT = 8'h80;

    // last index of the sixteen serial clock edges in one byte
    localparam logic [4:0] LAST_EDGE = 5'h0f;

    typedef struct packed {
        logic       rsv7;
        logic       bit_order;
        logic       host_select;
        logic       clock_double;
        logic       rsv3;
        logic [1:0] clock_prescaler_select;
        logic       enable;
    } ctrl_a_t;

    typedef struct packed {
        logic       buffer_enable;
        logic       buffer_wait_receive;
        logic [2:0] rsv;
        logic       select_disable;
        logic [1:0] mode;
    } ctrl_b_t;

    typedef struct packed {
        logic       receive_complete_int_enable;
        logic       transfer_complete_int_enable;
        logic       tx_empty_int_enable;
        logic       select_trigger_int_enable;
        logic [2:0] rsv;
        logic       single_int_enable;
    } int_en_t;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
    } spi_out_t;

    typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;

endpackage

// ---- design/spi_host_client_controller.sv ----
// serial peripheral controller, host or client, normal or buffered
// assumes wishbone classic master on clk_i; pins come from another domain
//
// Operation
// - clock double halves host serial clock period; none as client
// - host prescaler field divides peripheral clock by 4, 16, 64 or 128
// - buffer enable gives two receive stages and one transmit stage
// - buffered, wait-receive clear: first word out is a dummy
// - wait-receive set, enabled, select high: data write loads shifter
// - select disable keeps host mode when select input goes low
// - mode field sets leading edge direction and sampling edge
// - serial clock idles low for rising lead, high for falling lead
// - buffered interrupt enables act only buffered, read zero otherwise
// - single enable raises interrupt in normal mode on transfer done
// - normal mode: transfer done flag set after each full byte
// - host with select low also sets transfer done flag
// - done flag clears on vector, or flag read then data access
// - data write during shifting sets collision; flag read then data access clears it, vector does not
// - receive complete high while unread data; write one clears
// - transfer complete set when shifter empty and no buffer data
// - data empty flag high while transmit buffer empty; write clears
// - select trigger flag set when host forced to client
// - select low as host clears host select and sets done
// - interrupt held while any enabled flag stays set
// - third byte with both receive stages full sets overflow
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps

module spi_host_client_controller (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // interrupt
    input  wire logic              vector_ack_i,
    output logic                   irq_o,
    // serial pins
    input  wire logic              sck_i,
    input  wire logic              mosi_i,
    input  wire logic              miso_i,
    input  wire logic              ss_n_i,
    output spi_pkg::spi_out_t      spi_o
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: {sck, mosi, miso, ss_n}
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic       sck_d_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_ff <= 4'h1;
            sync2_ff <= 4'h1;
            sck_d_ff <= 1'b0;
        end else begin
            sync1_ff <= {sck_i, mosi_i, miso_i, ss_n_i};
            sync2_ff <= sync1_ff;
            sck_d_ff <= sync2_ff[3];
        end
    end

    wire sck_s  = sync2_ff[3];
    wire mosi_s = sync2_ff[2];
    wire miso_s = sync2_ff[1];
    wire ss_low = ~sync2_ff[0];

    ////////////////////////////////////////////////////////////////////
    // registers and state
    spi_pkg::ctrl_a_t     cta_ff;
    spi_pkg::ctrl_b_t     ctb_ff;
    spi_pkg::int_en_t     ien_ff;
    spi_pkg::xfer_state_t st_ff;
    spi_pkg::spi_out_t    spi_ff;
    logic                 ack_ff;
    logic [31:0]          dat_ff;
    logic                 irq_ff;
    logic [4:0]           edge_cnt_ff;
    logic [6:0]           div_cnt_ff;
    logic [7:0]           tx_sh_ff;
    logic [7:0]           rx_sh_ff;
    logic                 pend_ff;
    logic [7:0]           txbuf_ff;
    logic                 txv_ff;
    logic [7:0]           rxd0_ff;
    logic [7:0]           rxd1_ff;
    logic [1:0]           rxcnt_ff;
    logic                 done_ff;
    logic                 write_collision_flag_ff;
    logic                 done_arm_ff;
    logic                 write_collision_flag_arm_ff;
    logic                 rxc_ff;
    logic                 txc_ff;
    logic                 ssi_ff;
    logic                 ovf_ff;

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign irq_o    = irq_ff;
    assign spi_o    = spi_ff;

    wire en       = cta_ff.enable;
    wire host     = cta_ff.host_select;
    wire buf_mode = ctb_ff.buffer_enable;
    wire cpol     = ctb_ff.mode[1];
    wire cpha     = ctb_ff.mode[0];
    wire lsb_1st  = cta_ff.bit_order;

    ////////////////////////////////////////////////////////////////////
    // bus decode; writes take effect on the edge that raises ack
    wire       bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire       wr       = bus_req & wb_we_i & wb_sel_i[0];
    wire       rd       = bus_req & ~wb_we_i;
    wire [5:0] idx      = wb_adr_i[7:2];
    wire [7:0] wd       = wb_dat_i[7:0];
    wire       hit_a    = idx == spi_pkg::IDX_CTRL_A;
    wire       hit_b    = idx == spi_pkg::IDX_CTRL_B;
    wire       hit_ie   = idx == spi_pkg::IDX_INT_EN;
    wire       hit_fl   = idx == spi_pkg::IDX_FLAGS;
    wire       hit_dat  = idx == spi_pkg::IDX_DATA;
    wire       data_acc = bus_req & hit_dat;
    wire       wr_data  = wr & hit_dat;
    wire       wr_fl    = wr & hit_fl & buf_mode;
    wire       rd_fl    = rd & hit_fl;

    ////////////////////////////////////////////////////////////////////
    // serial clock and edges
    wire [7:0] div_sel =
        (cta_ff.clock_prescaler_select == 2'h0) ?
            spi_pkg::DIVIDE_BY_FOUR :
        (cta_ff.clock_prescaler_select == 2'h1) ?
            spi_pkg::DIVIDE_BY_SIXTEEN :
        (cta_ff.clock_prescaler_select == 2'h2) ?
            spi_pkg::DIVIDE_BY_SIXTYFOUR :
            spi_pkg::DIVIDE_BY_ONETWENTYEIGHT;
    // half period in cycles less one, the half period halved again when doubled
    wire [7:0] half_m1 =
        ((div_sel >> 1) >> cta_ff.clock_double) - 8'h01;

    wire host_act   = en & host;
    wire client_act = en & ~host & ss_low;
    wire host_edge  = host_act & (st_ff == spi_pkg::ST_SHIFT)
                      & (div_cnt_ff == half_m1[6:0]);
    wire cli_edge   = client_act & (sck_s != sck_d_ff);
    wire edge_ev    = host ? host_edge : cli_edge;
    wire lead       = host ? (spi_ff.sck == cpol) : (sck_d_ff == cpol);
    wire samp       = edge_ev & (lead ^ cpha);
    wire setup      = edge_ev & ~(lead ^ cpha);
    wire in_bit     = host ? miso_s : mosi_s;
    wire byte_done  = edge_ev & (edge_cnt_ff == spi_pkg::LAST_EDGE);
    wire busy_any   = host ? (st_ff == spi_pkg::ST_SHIFT)
                           : (ss_low & (edge_cnt_ff != 5'h00));
    // host pushed out by an external select, unless disabled
    wire force_cli  = en & host & ~ctb_ff.select_disable & ss_low;

    wire [7:0] tx_shift = lsb_1st ? {1'b0, tx_sh_ff[7:1]}
                                  : {tx_sh_ff[6:0], 1'b0};
    wire       first_b  = lsb_1st ? tx_sh_ff[0] : tx_sh_ff[7];
    wire       next_b   = lsb_1st ? tx_sh_ff[1] : tx_sh_ff[6];
    wire [7:0] rx_next  = !samp ? rx_sh_ff :
                          lsb_1st ? {in_bit, rx_sh_ff[7:1]}
                                  : {rx_sh_ff[6:0], in_bit};

    // direct shifter load while idle and deselected
    wire direct_ld = wr_data & buf_mode & ctb_ff.buffer_wait_receive
                     & en & ~ss_low & ~pend_ff & ~busy_any;
    wire norm_ld   = wr_data & ~buf_mode & ~busy_any;
    wire buf_wr    = wr_data & buf_mode & ~direct_ld;
    wire reload    = byte_done & buf_mode & txv_ff;
    // an idle host with buffered data starts on the old shifter contents
    wire start     = host_act & (st_ff == spi_pkg::ST_IDLE) & ~force_cli
                     & (pend_ff | (buf_mode & txv_ff));

    ////////////////////////////////////////////////////////////////////
    // shift engine
    always_ff @(posedge clk_i) begin
        if (rst_i || !en || force_cli) begin
            st_ff       <= spi_pkg::ST_IDLE;
            edge_cnt_ff <= 5'h00;
            div_cnt_ff  <= 7'h00;
        end else begin
            case (st_ff)
                spi_pkg::ST_IDLE: begin
                    div_cnt_ff <= 7'h00;
                    if (start) begin
                        st_ff <= spi_pkg::ST_SHIFT;
                    end
                end
                spi_pkg::ST_SHIFT: begin
                    div_cnt_ff <= host_edge ? 7'h00 : div_cnt_ff + 7'h01;
                    if (byte_done) begin
                        st_ff <= spi_pkg::ST_IDLE;
                    end
                end
                default: st_ff <= spi_pkg::ST_IDLE;
            endcase
            if (!host && !ss_low) begin
                edge_cnt_ff <= 5'h00;
            end else if (edge_ev) begin
                edge_cnt_ff <= byte_done ? 5'h00 : edge_cnt_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_sh_ff <= spi_pkg::REG_RESET;
            rx_sh_ff <= spi_pkg::REG_RESET;
            pend_ff  <= 1'b0;
        end else begin
            rx_sh_ff <= rx_next;
            if (norm_ld || direct_ld) begin
                tx_sh_ff <= wd;
                pend_ff  <= 1'b1;
            end else if (reload) begin
                tx_sh_ff <= txbuf_ff;
                pend_ff  <= 1'b1;
            end else begin
                if (setup) begin
                    tx_sh_ff <= tx_shift;
                end
                if (start || byte_done) begin
                    pend_ff <= 1'b0;
                end
            end
        end
    end

    // pin drivers; all registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spi_ff <= '0;
        end else begin
            spi_ff.sck_oe  <= host_act;
            spi_ff.mosi_oe <= host_act;
            spi_ff.miso_oe <= client_act;
            if (host_edge) begin
                spi_ff.sck <= ~spi_ff.sck;
            end else if (st_ff == spi_pkg::ST_IDLE || !host_act) begin
                spi_ff.sck <= cpol;
            end
            if (setup) begin
                spi_ff.mosi <= cpha ? first_b : next_b;
                spi_ff.miso <= cpha ? first_b : next_b;
            end else if (edge_cnt_ff == 5'h00 && !cpha) begin
                spi_ff.mosi <= first_b;
                spi_ff.miso <= first_b;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit buffer and two-stage receive buffer
    wire push   = byte_done & buf_mode;
    wire pop    = rd & hit_dat & buf_mode & (rxcnt_ff != 2'h0);
    wire ovf_ev = push & ~pop & (rxcnt_ff == 2'h2);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txbuf_ff <= spi_pkg::REG_RESET;
            txv_ff   <= 1'b0;
            rxd0_ff  <= spi_pkg::REG_RESET;
            rxd1_ff  <= spi_pkg::REG_RESET;
            rxcnt_ff <= 2'h0;
        end else begin
            if (buf_wr) begin
                txbuf_ff <= wd;
                txv_ff   <= 1'b1;
            end else if (reload) begin
                txv_ff   <= 1'b0;
            end
            if (byte_done && !buf_mode) begin
                rxd0_ff <= rx_next;
            end
            case ({push, pop})
                2'b10: begin
                    if (rxcnt_ff == 2'h0) begin
                        rxd0_ff <= rx_next;
                    end else if (rxcnt_ff == 2'h1) begin
                        rxd1_ff <= rx_next;
                    end
                    if (rxcnt_ff != 2'h2) begin
                        rxcnt_ff <= rxcnt_ff + 2'h1;
                    end
                end
                2'b01: begin
                    rxd0_ff  <= rxd1_ff;
                    rxcnt_ff <= rxcnt_ff - 2'h1;
                end
                2'b11: begin
                    if (rxcnt_ff == 2'h1) begin
                        rxd0_ff <= rx_next;
                    end else begin
                        rxd0_ff <= rxd1_ff;
                        rxd1_ff <= rx_next;
                    end
                end
                default: rxcnt_ff <= rxcnt_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flags; a set in the same cycle as a clear wins, except data empty, where a data write beats the reload that would set it
    wire done_set  = (byte_done & ~buf_mode) | force_cli;
    wire done_clr  = vector_ack_i | (data_acc & done_arm_ff);
    wire write_collision_flag_set = wr_data & ~buf_mode & busy_any;
    wire write_collision_flag_clr = data_acc & write_collision_flag_arm_ff;
    wire rxc_clr   = (wr_fl & wd[spi_pkg::POS_RXC])
                     | (pop & ~push & (rxcnt_ff == 2'h1));
    wire txc_set   = byte_done & buf_mode & ~txv_ff;
    wire dre       = ~txv_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_ff      <= 1'b0;
            write_collision_flag_ff     <= 1'b0;
            done_arm_ff  <= 1'b0;
            write_collision_flag_arm_ff <= 1'b0;
            rxc_ff       <= 1'b0;
            txc_ff       <= 1'b0;
            ssi_ff       <= 1'b0;
            ovf_ff       <= 1'b0;
        end else begin
            done_ff  <= done_set | (done_ff & ~done_clr);
            write_collision_flag_ff <= write_collision_flag_set | (write_collision_flag_ff & ~write_collision_flag_clr);
            if (rd_fl) begin
                done_arm_ff  <= done_ff;
                write_collision_flag_arm_ff <= write_collision_flag_ff;
            end else if (data_acc) begin
                done_arm_ff  <= 1'b0;
                write_collision_flag_arm_ff <= 1'b0;
            end
            rxc_ff <= push | (rxc_ff & ~rxc_clr);
            txc_ff <= txc_set
                      | (txc_ff & ~(wr_fl & wd[spi_pkg::POS_TXC]));
            ssi_ff <= force_cli
                      | (ssi_ff & ~(wr_fl & wd[spi_pkg::POS_SSI]));
            ovf_ff <= ovf_ev
                      | (ovf_ff & ~((wr_fl & wd[spi_pkg::POS_OVF])
                                    | (rd & hit_dat & buf_mode)));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux and control writes
    logic [7:0] flags_rd;

    always_comb begin
        flags_rd = 8'h00;
        if (buf_mode) begin
            flags_rd[spi_pkg::POS_RXC] = rxc_ff;
            flags_rd[spi_pkg::POS_TXC] = txc_ff;
            flags_rd[spi_pkg::POS_DRE] = dre;
            flags_rd[spi_pkg::POS_SSI] = ssi_ff;
            flags_rd[spi_pkg::POS_OVF] = ovf_ff;
        end else begin
            flags_rd[spi_pkg::POS_DONE]  = done_ff;
            flags_rd[spi_pkg::POS_WRITE_COLLISION_FLAG] = write_collision_flag_ff;
        end
    end

    wire [7:0] ien_rd = buf_mode ? ien_ff
                                 : (ien_ff & spi_pkg::INT_EN_NORMAL);
    wire [7:0] reg_rd = hit_a   ? cta_ff :
                        hit_b   ? ctb_ff :
                        hit_ie  ? ien_rd :
                        hit_fl  ? flags_rd :
                        hit_dat ? rxd0_ff : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cta_ff <= spi_pkg::REG_RESET;
            ctb_ff <= spi_pkg::REG_RESET;
            ien_ff <= spi_pkg::REG_RESET;
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req;
            if (rd) begin
                dat_ff <= {24'h00_0000, reg_rd};
            end
            if (wr && hit_a) begin
                cta_ff <= wd & spi_pkg::CTRL_A_MASK;
            end else if (force_cli) begin
                cta_ff.host_select <= 1'b0;
            end
            if (wr && hit_b) begin
                ctb_ff <= wd & spi_pkg::CTRL_B_MASK;
            end
            if (wr && hit_ie) begin
                ien_ff <= wd & spi_pkg::INT_EN_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt request, held while an enabled flag stays set
    wire irq_buf = (rxc_ff & ien_ff.receive_complete_int_enable)
                 | (txc_ff & ien_ff.transfer_complete_int_enable)
                 | (dre & ien_ff.tx_empty_int_enable)
                 | (ssi_ff & ien_ff.select_trigger_int_enable);
    wire irq_nrm = ien_ff.single_int_enable & (done_ff | write_collision_flag_ff);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= buf_mode ? irq_buf : irq_nrm;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_disabled_idle: assert property (
        !en |=> (st_ff == spi_pkg::ST_IDLE) && !spi_ff.sck_oe)
        else $error("disabled block still active");
    a_sck_idle_level: assert property (
        (st_ff == spi_pkg::ST_IDLE) ##1 (st_ff == spi_pkg::ST_IDLE)
        |-> spi_ff.sck == $past(cpol))
        else $error("serial clock idle level wrong");
    a_divide_by_four_spacing: assert property (
        host_edge && !cta_ff.clock_double
        && cta_ff.clock_prescaler_select == 2'h0 |=> !host_edge ##1 1'b1)
        else $error("divide by four too fast");
    a_double_rate: assert property (
        host_edge && cta_ff.clock_double && !byte_done && !force_cli
        && cta_ff.clock_prescaler_select == 2'h0 && $stable(cta_ff)
        |=> host_edge || !en)
        else $error("doubled clock not doubled");
    a_done_flag_set: assert property (
        byte_done && !buf_mode |=> done_ff)
        else $error("transfer done flag not set");
    a_write_collision_flag_set: assert property (
        write_collision_flag_set |=> write_collision_flag_ff)
        else $error("write collision not flagged");
    a_host_dropped: assert property (
        force_cli && !(wr && hit_a) |=> !host && done_ff)
        else $error("host not forced to client");
    a_irq_held: assert property (
        !buf_mode && ien_ff.single_int_enable && done_ff
        && $stable(ctb_ff) |=> irq_ff)
        else $error("interrupt not raised");
    a_ie_hidden: assert property (
        rd && hit_ie && !buf_mode |=> dat_ff[7:4] == 4'h0)
        else $error("buffered enables visible");
    a_dre_cleared: assert property (
        buf_wr |=> !dre)
        else $error("data empty not cleared by write");

endmodule

// ---- test/spi_client_model.sv ----
// behavioural serial client on the far side of the host pins
// assumes mode 0 framing; the bench drives its select line
`timescale 1ns/1ps

module spi_client_model (
    // serial lines
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       sel_n_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic [7:0]      rx_o
);
    logic [7:0] sh_ff;
    initial begin
        sh_ff  = 8'h00;
        rx_o   = 8'h00;
        miso_o = 1'b0;
    end
    ////////////////////////////////////////
    always @(negedge sel_n_i) begin
        sh_ff  = tx_i;
        miso_o = tx_i[7];
    end
    // sample on the rising lead, set up on the falling trail
    always @(posedge sck_i) if (!sel_n_i) rx_o = {rx_o[6:0], mosi_i};
    always @(negedge sck_i) if (!sel_n_i) begin
        sh_ff  = {sh_ff[6:0], 1'b0};
        miso_o = sh_ff[7];
    end
    // released line must not keep the last bit
    always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule

// ---- test/spi_host_client_controller_tb.sv ----
// register and host transfer checks of the serial controller
// assumes the client model answers on miso with a fixed byte
`timescale 1ns/1ps

module spi_host_client_controller_tb;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, vack = 0;
    logic ss_n = 1, sel_n = 1, miso;
    logic [7:0] adr = 8'h00, rx, rd;
    logic [31:0] dat = 32'h0000_0000, wb_dat_o;
    logic wb_ack_o, irq_o;
    spi_pkg::spi_out_t spi_o;
    int fails = 0, checked = 0, cycles = 0;
    real t;
    always #2.5 clk_i = ~clk_i;
    spi_host_client_controller uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .vector_ack_i(vack), .irq_o(irq_o),
        .sck_i(1'b0), .mosi_i(1'b0), .miso_i(miso), .ss_n_i(ss_n),
        .spi_o(spi_o));
    spi_client_model peer (.sck_i(spi_o.sck), .mosi_i(spi_o.mosi),
        .sel_n_i(sel_n), .tx_i(8'h3c), .miso_o(miso), .rx_o(rx));
    ////////////////////////////////////////
    task automatic close_out;
        if (fails == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h00_0000, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o[7:0];
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        cmp($sformatf("reg %h", a), e, rd);
    endtask
    // start a byte and time one serial half period in ns
    task automatic xfer(input logic [7:0] d, input real half);
        wr(8'h10, d);
        @(posedge spi_o.sck);
        t = $realtime;
        @(negedge spi_o.sck);
        checked++;
        if ($realtime - t != half) begin
            fails++;
            $display("mismatch half exp %f got %f", half, $realtime - t);
        end
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        for (int i = 0; i < 5; i++) chk(8'(i * 4), 8'h00);
        chk(8'h40, 8'h00);
        wr(8'h08, 8'hf1);
        chk(8'h08, 8'h01);
        wr(8'h04, 8'h02);
        wr(8'h00, 8'h23);
        repeat (4) @(posedge clk_i);
        cmp("idle high", 8'h01, {7'h00, spi_o.sck});
        wr(8'h04, 8'h00);
        repeat (4) @(posedge clk_i);
        cmp("idle low", 8'h00, {7'h00, spi_o.sck});
        sel_n <= 0;
        xfer(8'ha5, 40.0);
        wr(8'h10, 8'h5a);
        // the collision raises irq at once, so wait out the byte instead
        repeat (120) @(posedge clk_i);
        cmp("peer rx", 8'ha5, rx);
        chk(8'h0c, 8'hc0);
        chk(8'h10, 8'h3c);
        chk(8'h0c, 8'h00);
        cmp("irq", 8'h00, {7'h00, irq_o});
        sel_n <= 1;
        wr(8'h00, 8'h33);
        sel_n <= 0;
        xfer(8'h81, 20.0);
        while (irq_o !== 1'b1) @(posedge clk_i);
        chk(8'h0c, 8'h80);
        chk(8'h10, 8'h3c);
        sel_n <= 1;
        wr(8'h00, 8'h23);
        ss_n <= 0;
        repeat (8) @(posedge clk_i);
        chk(8'h00, 8'h03);
        chk(8'h0c, 8'h80);
        // no byte moved since the last one, so data still holds it
        chk(8'h10, 8'h3c);
        ss_n <= 1;
        wr(8'h04, 8'h04);
        wr(8'h00, 8'h23);
        ss_n <= 0;
        repeat (8) @(posedge clk_i);
        chk(8'h00, 8'h23);
        ss_n <= 1;
        // fastest host rates: doubled, then plain divide by four
        for (int m = 0; m < 2; m++) begin
            wr(8'h00, m ? 8'h21 : 8'h31);
            xfer(8'h00, m ? 10.0 : 5.0);
            while (irq_o !== 1'b1) @(posedge clk_i);
            vack <= 1;
            @(posedge clk_i);
            vack <= 0;
            chk(8'h0c, 8'h00);
        end
        wr(8'h00, 8'h22);
        wr(8'h10, 8'h11);
        repeat (60) @(posedge clk_i);
        cmp("sck oe", 8'h00, {7'h00, spi_o.sck_oe});
        chk(8'h0c, 8'h00);
        wr(8'h04, 8'h80);
        // select trigger still set from the forced host exit
        chk(8'h0c, 8'h30);
        wr(8'h08, 8'hf1);
        chk(8'h08, 8'hf1);
        cmp("irq", 8'h01, {7'h00, irq_o});
        wr(8'h0c, 8'h10);
        wr(8'h08, 8'hd1);
        cmp("irq", 8'h00, {7'h00, irq_o});
        sel_n <= 0;
        wr(8'h00, 8'h23);
        while (irq_o !== 1'b1) @(posedge clk_i);
        chk(8'h0c, 8'he0);
        chk(8'h10, 8'h3c);
        chk(8'h0c, 8'h60);
        wr(8'h10, 8'h77);
        chk(8'h0c, 8'h40);
        close_out();
    end
endmodule
